// [psm_pkg.sv]
// Purpose: Shared constants and types for the programmable synchronous memory port.
// Assumes: Wide port instance: 64-bit data, 8 byte lanes, 20 word-address bits.
// Notes:   Latency settings are two-bit fields, values zero to three.
`default_nettype none
package psm_pkg;
    localparam int ADDR_W  = 20;   // Word address width
    localparam int DATA_W  = 64;   // Data bus width
    localparam int BE_W    = 8;    // Byte lanes
    localparam int SPACE_W = 2;    // Chip-enable space index width
    localparam int N_SPACE = 4;    // Number of chip-enable spaces
    localparam int CNT_W   = 3;    // Cycle counter width, holds latency plus one

    localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;  // Counter start value
    localparam logic [CNT_W-1:0] CNT_STEP = 3'h1;  // Counter increment

    // Per-space secondary control settings
    typedef struct packed {
        logic [1:0] read_latency_sel;       // Read latency in interface cycles
        logic [1:0] write_latency_sel;      // Write latency in interface cycles
        logic       chip_select_extend;     // Hold select while output enable is on
        logic       strobe_is_read_enable;  // Strobe acts as read enable, no deselect
        logic       interface_clock_sel;    // Zero: first clock out, one: second
    } psm_cfg_t;

    localparam psm_cfg_t CFG_RST = psm_cfg_t'(7'h00);  // Settings after reset

    // One access request from the controller
    typedef struct packed {
        logic               write;  // One for write, zero for read
        logic [SPACE_W-1:0] space;  // Chip-enable space
        logic [ADDR_W-1:0]  addr;   // Word address
        logic [BE_W-1:0]    be;     // Byte enables, active high
        logic [DATA_W-1:0]  wdata;  // Write data
    } psm_req_t;

    // Settings write from the controller
    typedef struct packed {
        logic [SPACE_W-1:0] space;  // Space being programmed
        psm_cfg_t           cfg;    // New settings
    } psm_cfgwr_t;
endpackage : psm_pkg
`default_nettype wire

// [psm_sync2.sv]
// Purpose: Two-flop synchroniser for one level or toggle bit.
// Assumes: Destination clock given on i_clk.
// Notes:   The first flop feeds only the second one.
`timescale 1ns/10ps
`default_nettype none
module psm_sync2 (
    input  wire logic i_clk,    // Destination clock
    input  wire logic i_rst_n,  // Asynchronous reset, active low
    input  wire logic i_en,     // Clock enable
    input  wire logic i_d,      // Bit from the other domain
    output logic      o_q       // Synchronised bit
);
    logic meta_q;  // First stage, read only by the second

    // Two stages to let metastability settle
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_q <= 1'b0;
            o_q    <= 1'b0;
        end else if (i_en) begin
            meta_q <= i_d;
            o_q    <= meta_q;
        end
    end
endmodule : psm_sync2
`default_nettype wire

// [psm_port.sv]
// Purpose: Programmable synchronous memory port for SRAM or synchronous FIFO.
// Assumes: i_link_clk is the selected interface clock; o_interface_clock_sel steers the outside mux.
// Notes:   One word per request; core and link exchange requests by toggle handshake.
// Contract
// R01: Read latency zero to three cycles
// R02: Write latency zero to three cycles
// R03: Extend off: select drops after command
// R04: Extend on: select held with output enable
// R05: Strobe off: address strobe, deselect cycles
// R06: Strobe on: read enable, no deselect
// R07: Interface runs on selected clock output
// R08: Settings held per chip-enable space
// R09: Sample and update on rising edge
// R10: Control pins act as strobe, enable, write
// R11: Memory returns data at programmed latency
`timescale 1ns/10ps
`default_nettype none
module psm_port
    import psm_pkg::*;
(
    input  wire logic                i_clk,                        // Core clock, 50 MHz
    input  wire logic                i_rst_n,                      // Asynchronous reset, active low
    input  wire logic                i_ce,                         // Clock enable, freezes state
    input  wire logic                i_link_clk,                   // Selected interface clock
    input  wire logic                i_cfg_we,                     // Settings write strobe
    input  wire psm_pkg::psm_cfgwr_t i_cfg,                        // Settings and space
    input  wire logic                i_req_valid,                  // Request valid
    input  wire psm_pkg::psm_req_t   i_req,                        // Request payload
    output logic                     o_req_ready,                  // Ready for a request
    output logic                     o_rd_valid,                   // Read data pulse
    output logic [DATA_W-1:0]        o_rd_data,                    // Read data
    output logic                     o_interface_clock_sel,        // Clock output choice
    output logic                     o_chip_select_n,              // Chip select, active low
    output logic [BE_W-1:0]          o_byte_enable_n,              // Byte enables, active low
    output logic [ADDR_W-1:0]        o_ext_address,                // Word address
    output logic                     o_addr_strobe_or_read_enable_n, // Shared strobe, active low
    output logic                     o_sync_output_enable_n,       // Output enable, active low
    output logic                     o_sync_write_enable_n,        // Write enable, active low
    input  wire logic [DATA_W-1:0]   i_ext_data_bus,               // Data bus in
    output logic [DATA_W-1:0]        o_ext_data_bus,               // Data bus out
    output logic                     o_ext_data_bus_oe             // Data bus drive enable
);
    ////////////////////////////////////////////////////////////////////////////
    // Core domain
    psm_cfg_t cfg_q [N_SPACE];  // Settings table
    psm_req_t req_q;            // Request held across the crossing
    psm_cfg_t cur_cfg_q;        // Settings of the held request
    logic     req_tgl_q;        // Request toggle to the link
    logic     ack_s;            // Synchronised acknowledge toggle
    logic     ack_seen_q;       // Last acknowledge handled
    logic     ack_new;          // Link finished an access
    logic     link_ack_tgl_q;   // Acknowledge toggle from the link
    logic     take;             // Request accepted this cycle
    logic [DATA_W-1:0] rd_data_q; // Captured read data, written by the link, read after acknowledge

    assign take    = i_req_valid && o_req_ready;
    assign ack_new = ack_s != ack_seen_q;

    // Settings table, one entry per space
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < N_SPACE; i++) begin
                cfg_q[i] <= CFG_RST;
            end
        end else if (i_ce && i_cfg_we) begin
            cfg_q[i_cfg.space] <= i_cfg.cfg;  // [R08]
        end
    end

    // Accept a request and hand it to the link; payload stays still until acknowledged
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            req_q                 <= '0;
            cur_cfg_q             <= CFG_RST;
            req_tgl_q             <= 1'b0;
            o_req_ready           <= 1'b1;
            o_interface_clock_sel <= 1'b0;
        end else if (i_ce) begin
            if (take) begin
                req_q                 <= i_req;
                cur_cfg_q             <= cfg_q[i_req.space];
                o_interface_clock_sel <= cfg_q[i_req.space].interface_clock_sel;  // [R07]
                req_tgl_q             <= ~req_tgl_q;
                o_req_ready           <= 1'b0;
            end else if (ack_new) begin
                o_req_ready <= 1'b1;
            end
        end
    end

    // Return read data once the link acknowledges
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_seen_q <= 1'b0;
            o_rd_valid <= 1'b0;
            o_rd_data  <= '0;
        end else if (i_ce) begin
            o_rd_valid <= ack_new && !req_q.write;
            if (ack_new) begin
                ack_seen_q <= ack_s;
                if (!req_q.write) begin
                    o_rd_data <= rd_data_q;  // Stable: link holds it until next request
                end
            end
        end
    end

    psm_sync2 u_ack_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_en    (i_ce),
        .i_d     (link_ack_tgl_q),
        .o_q     (ack_s)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Link domain
    typedef enum logic [1:0] {PSM_IDLE, PSM_WAIT, PSM_DESEL} psm_state_t;

    psm_state_t       state_q;    // Access state
    psm_cfg_t         lcfg_q;     // Settings latched at command
    logic             lwrite_q;   // Access is a write
    logic [CNT_W-1:0] since_q;    // Interface cycles since the command edge
    logic             req_s;      // Synchronised request toggle
    logic             req_seen_q; // Last request handled
    logic             lce_s;      // Synchronised clock enable
    logic             lreq_new;   // New request waiting

    assign lreq_new = req_s != req_seen_q;

    // Latency reached when the counter matches the setting
    function automatic logic lat_hit(input logic [CNT_W-1:0] cnt, input logic [1:0] lat);
        lat_hit = cnt == {1'b0, lat};
    endfunction : lat_hit

    psm_sync2 u_req_sync (
        .i_clk   (i_link_clk),
        .i_rst_n (i_rst_n),
        .i_en    (lce_s),
        .i_d     (req_tgl_q),
        .o_q     (req_s)
    );

    // Enable must cross too; it is never frozen itself or it could not wake
    psm_sync2 u_ce_sync (
        .i_clk   (i_link_clk),
        .i_rst_n (i_rst_n),
        .i_en    (1'b1),
        .i_d     (i_ce),
        .o_q     (lce_s)
    );

    // Pin sequencer: every pin changes only after a rising interface edge
    always_ff @(posedge i_link_clk or negedge i_rst_n) begin  // [R07] [R09]
        if (!i_rst_n) begin
            state_q                        <= PSM_IDLE;
            lcfg_q                         <= CFG_RST;
            lwrite_q                       <= 1'b0;
            since_q                        <= CNT_ZERO;
            req_seen_q                     <= 1'b0;
            link_ack_tgl_q                 <= 1'b0;
            rd_data_q                      <= '0;
            o_chip_select_n                <= 1'b1;
            o_byte_enable_n                <= '1;
            o_ext_address                  <= '0;
            o_addr_strobe_or_read_enable_n <= 1'b1;
            o_sync_output_enable_n         <= 1'b1;
            o_sync_write_enable_n          <= 1'b1;
            o_ext_data_bus                 <= '0;
            o_ext_data_bus_oe              <= 1'b0;
        end else if (lce_s) begin
            unique case (state_q)
                PSM_IDLE: begin
                    if (lreq_new) begin
                        // Command cycle
                        req_seen_q      <= req_s;
                        lcfg_q          <= cur_cfg_q;
                        lwrite_q        <= req_q.write;
                        since_q         <= CNT_ZERO;
                        o_chip_select_n <= 1'b0;
                        o_byte_enable_n <= ~req_q.be;
                        o_ext_address   <= req_q.addr;
                        // Address strobe on every command, read enable only on reads
                        o_addr_strobe_or_read_enable_n <=
                            cur_cfg_q.strobe_is_read_enable && req_q.write;  // [R05] [R06] [R10]
                        o_sync_output_enable_n <= req_q.write;  // [R10]
                        o_sync_write_enable_n  <= !req_q.write; // [R10]
                        o_ext_data_bus         <= req_q.wdata;
                        o_ext_data_bus_oe      <=
                            req_q.write && lat_hit(CNT_ZERO, cur_cfg_q.write_latency_sel);  // [R02]
                        state_q <= PSM_WAIT;
                    end
                end
                PSM_WAIT: begin
                    since_q                        <= since_q + CNT_STEP;
                    o_addr_strobe_or_read_enable_n <= 1'b1;
                    o_sync_write_enable_n          <= 1'b1;
                    // Select drops after the command unless held for the FIFO glue
                    o_chip_select_n <= !(lcfg_q.chip_select_extend && !lwrite_q);  // [R03] [R04]
                    if (lwrite_q) begin
                        if (o_ext_data_bus_oe) begin
                            o_ext_data_bus_oe <= 1'b0;
                            link_ack_tgl_q    <= ~link_ack_tgl_q;
                            state_q <= lcfg_q.strobe_is_read_enable ? PSM_IDLE : PSM_DESEL;
                        end else if (lat_hit(since_q + CNT_STEP, lcfg_q.write_latency_sel)) begin
                            o_ext_data_bus_oe <= 1'b1;  // [R02]
                        end
                    end else if (lat_hit(since_q, lcfg_q.read_latency_sel)) begin
                        // No ready handshake: data is taken at the programmed edge
                        rd_data_q              <= i_ext_data_bus;  // [R01] [R09] [R11]
                        o_sync_output_enable_n <= 1'b1;
                        o_chip_select_n        <= 1'b1;
                        link_ack_tgl_q         <= ~link_ack_tgl_q;
                        state_q <= lcfg_q.strobe_is_read_enable ? PSM_IDLE : PSM_DESEL;  // [R06]
                    end
                end
                PSM_DESEL: begin
                    // Deselect: strobe with select off, one cycle
                    if (o_addr_strobe_or_read_enable_n) begin
                        o_chip_select_n                <= 1'b1;
                        o_addr_strobe_or_read_enable_n <= 1'b0;  // [R05]
                    end else begin
                        o_addr_strobe_or_read_enable_n <= 1'b1;
                        state_q                        <= PSM_IDLE;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_read_cmd;
        !o_chip_select_n && !o_sync_output_enable_n && state_q == PSM_WAIT && since_q == CNT_ZERO;
    endsequence

    a_rd_lat_capture: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)  // [R01]
        (lce_s && state_q == PSM_WAIT && !lwrite_q && $changed(link_ack_tgl_q) == 1'b0
         ##1 $changed(link_ack_tgl_q) && $past(lce_s)) |-> $past(since_q) == {1'b0, lcfg_q.read_latency_sel})
        else $error("read data not captured at programmed latency");

    a_wr_lat_drive: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)  // [R02]
        $rose(o_ext_data_bus_oe) && state_q == PSM_WAIT
        |-> since_q == {1'b0, lcfg_q.write_latency_sel})
        else $error("write data driven at wrong latency");

    a_cs_short_std: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)  // [R03]
        (state_q == PSM_WAIT && !lcfg_q.chip_select_extend && since_q != CNT_ZERO) |-> o_chip_select_n)
        else $error("select held past command without extension");

    a_cs_extend_fifo: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)  // [R04]
        (lcfg_q.chip_select_extend && !o_sync_output_enable_n) |-> !o_chip_select_n)
        else $error("select dropped while output enable active");

    a_deselect_cycle: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)  // [R05]
        (state_q == PSM_DESEL && lce_s && o_addr_strobe_or_read_enable_n)
        |=> (o_chip_select_n && !o_addr_strobe_or_read_enable_n) ##1 o_addr_strobe_or_read_enable_n)
        else $error("deselect cycle malformed");

    a_no_deselect: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)  // [R06]
        lcfg_q.strobe_is_read_enable |-> state_q != PSM_DESEL)
        else $error("deselect issued in read enable mode");

    a_clk_sel_track: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // [R07]
        take && i_ce |=> o_interface_clock_sel == $past(cfg_q[i_req.space].interface_clock_sel))
        else $error("clock choice not taken from space settings");

    a_cfg_store: assert property (@(posedge i_clk) disable iff (!i_rst_n)  // [R08]
        i_ce && i_cfg_we |=> cfg_q[$past(i_cfg.space)] == $past(i_cfg.cfg))
        else $error("settings not stored for space");

    a_write_pins: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)  // [R10]
        !o_sync_write_enable_n |-> !o_chip_select_n && o_sync_output_enable_n ##1 o_sync_write_enable_n || !lce_s)
        else $error("write enable without select or too long");

    // A read command must show the strobe low in both strobe modes, and never write enable
    a_rd_cmd_pins: assert property (@(posedge i_link_clk) disable iff (!i_rst_n)  // [R10]
        s_read_cmd |-> !o_addr_strobe_or_read_enable_n && o_sync_write_enable_n)
        else $error("read command pins malformed");
endmodule : psm_port
`default_nettype wire

// [psm_mem_model.sv]
// Purpose: Behavioural synchronous SRAM standing on the far side of the memory port.
// Assumes: i_rl and i_wl carry the latencies programmed for the space being accessed.
// Notes:   Outside its read slot the model drives the inverse of the last word, never a held value.
`timescale 1ns/10ps
`default_nettype none
module psm_mem_model (
    input  wire logic        i_clk,      // Selected interface clock
    input  wire logic        i_cs_n,     // Chip select, active low
    input  wire logic [7:0]  i_be_n,     // Byte enables, active low
    input  wire logic [19:0] i_addr,     // Word address
    input  wire logic        i_stb_n,    // Shared strobe, active low
    input  wire logic        i_oe_n,     // Output enable, active low
    input  wire logic        i_we_n,     // Write enable, active low
    input  wire logic [1:0]  i_rl,       // Read latency of this access
    input  wire logic [1:0]  i_wl,       // Write latency of this access
    input  wire logic [63:0] i_wdata,    // Write data from the port
    input  wire logic        i_wdata_oe, // Port drives the data bus
    output logic      [63:0] o_rdata     // Read data to the port
);
    ////////////////////////////////////////////////////////////////
    logic [63:0] mem [logic [19:0]];   // Sparse storage, unwritten words read as zero
    logic [19:0] ra;                   // Latched read address
    logic [19:0] wa;                   // Latched write address
    logic [7:0]  wb;                   // Latched byte enables
    int          rc = -1;              // Edges left to the read slot
    int          wc = -1;              // Edges left to the write slot
    logic        drv = 1'b0;           // Read word is on the bus
    initial o_rdata = 64'h0;
    // Pins are looked at just after each edge, once the port's flops have moved
    always @(posedge i_clk) begin
        #2;
        if (drv) begin  // Hold time over, so the bus stops showing the word
            o_rdata = ~o_rdata;
            drv = 1'b0;
        end
        if (rc > 0) rc--;
        if (wc > 0) wc--;
        if (!i_cs_n && !i_stb_n && !i_oe_n) begin  // Read command
            ra = i_addr;
            rc = int'(i_rl);
        end
        if (!i_cs_n && !i_we_n) begin  // Write command
            wa = i_addr;
            wb = ~i_be_n;
            wc = int'(i_wl);
        end
        if (rc == 0) begin  // Word valid before edge L+1, no handshake
            o_rdata = mem.exists(ra) ? mem[ra] : 64'h0;
            drv = 1'b1;
            rc = -1;
        end
        if (wc == 0) begin  // A missed data slot stores nothing
            if (i_wdata_oe === 1'b1) begin
                if (!mem.exists(wa)) mem[wa] = 64'h0;
                for (int b = 0; b < 8; b++) if (wb[b]) mem[wa][8*b +: 8] = i_wdata[8*b +: 8];
            end
            wc = -1;
        end
    end
endmodule : psm_mem_model
`default_nettype wire

// [tb_top.sv]
// Purpose: Self-checking bench for the programmable synchronous memory port.
// Assumes: Link clock runs free at 64 ns, unrelated in phase to the 50 MHz core clock.
// Notes:   Each space gets two settings sets; write, partial write and read per set.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import psm_pkg::*;
    ////////////////////////////////////////////////////////////////
    logic clk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, cfg_we = 1'b0, req_valid = 1'b0;
    logic ready, rd_valid, clk_sel, cs_n, stb_n, oe_n, we_n, doe;
    logic [63:0] rd_data, dout, din, mdata;   // Data paths
    logic [7:0]  be_n;                        // Byte enables at the pins
    logic [19:0] addr;                        // Address at the pins
    logic [1:0]  cur_rl, cur_wl;              // Latencies told to the memory
    psm_cfgwr_t  cfg;                         // Settings write
    psm_req_t    req;                         // Request payload
    logic [63:0] refm [logic [19:0]];         // Reference memory
    int n_errors = 0, checks_done = 0, ncs, ndes, ncmd;
    always #10 clk = ~clk;
    initial begin  // Offset keeps the two clocks from lining up
        #3;
        forever #32 link_clk = ~link_clk;
    end
    assign din = doe ? dout : mdata;  // Bus level from both drivers
    ////////////////////////////////////////////////////////////////
    psm_port psm_port_i (.i_clk(clk), .i_rst_n(rst_n), .i_ce(1'b1), .i_link_clk(link_clk),
        .i_cfg_we(cfg_we), .i_cfg(cfg), .i_req_valid(req_valid), .i_req(req), .o_req_ready(ready),
        .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_interface_clock_sel(clk_sel),
        .o_chip_select_n(cs_n), .o_byte_enable_n(be_n), .o_ext_address(addr),
        .o_addr_strobe_or_read_enable_n(stb_n), .o_sync_output_enable_n(oe_n),
        .o_sync_write_enable_n(we_n), .i_ext_data_bus(din), .o_ext_data_bus(dout),
        .o_ext_data_bus_oe(doe));
    psm_mem_model psm_mem_model_i (.i_clk(link_clk), .i_cs_n(cs_n), .i_be_n(be_n), .i_addr(addr),
        .i_stb_n(stb_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_rl(cur_rl), .i_wl(cur_wl),
        .i_wdata(din), .i_wdata_oe(doe), .o_rdata(mdata));
    // Pin monitor: select cycles, deselects and commands per access
    always @(posedge link_clk) begin
        if (cs_n === 1'b0) ncs++;
        if (cs_n === 1'b1 && stb_n === 1'b0) ndes++;
        if (cs_n === 1'b0 && (we_n === 1'b0 || stb_n === 1'b0)) ncmd++;
    end
    ////////////////////////////////////////////////////////////////
    task automatic final_report;
        if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic check(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : check
    // Settings set i: every latency, both extend and strobe modes, both clocks
    function automatic psm_cfg_t cfg_of(input int i);
        psm_cfg_t c;
        logic [2:0] v;
        v = i[2:0];
        c.read_latency_sel = v[1:0];
        c.write_latency_sel = v[1:0] + 2'h1;
        c.chip_select_extend = v[2];
        c.strobe_is_read_enable = v[2] ^ v[0];
        c.interface_clock_sel = v[1];
        return c;
    endfunction : cfg_of
    task automatic program_space(input int i);
        @(negedge clk);
        cfg.space = i[1:0];
        cfg.cfg = cfg_of(i);
        cfg_we = 1'b1;
        @(negedge clk);
        cfg_we = 1'b0;
    endtask : program_space
    task automatic access(input logic w, input int i, input logic [19:0] a, input logic [7:0] b,
                          input logic [63:0] d);
        psm_cfg_t c;
        logic [63:0] e;
        int k;
        c = cfg_of(i);
        cur_rl = c.read_latency_sel;
        cur_wl = c.write_latency_sel;
        ncs = 0;
        ndes = 0;
        ncmd = 0;
        @(negedge clk);
        req = '{w, i[1:0], a, b, d};
        req_valid = 1'b1;
        k = 0;
        while (ready !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);  // Taken at the edge just passed
        @(negedge clk);  // Still valid while not ready, so it must be ignored
        req_valid = 1'b0;
        while (ready !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 2000) begin  // Hang: count it and stop
            check(1'b0, "access never completed");
            final_report();
        end
        check(rd_valid === !w, "read pulse");
        if (w) begin  // Reference merge by byte enable
            e = refm.exists(a) ? refm[a] : 64'h0;
            for (int j = 0; j < 8; j++) if (b[j]) e[8*j +: 8] = d[8*j +: 8];
            refm[a] = e;
        end
        else check(rd_data === refm[a], "read data");
        repeat (30) @(negedge clk);  // Let the deselect cycles finish
        check(ncmd == 1, "command count");
        check(ncs == ((!w && c.chip_select_extend) ? int'(c.read_latency_sel) + 1 : 1), "select length");
        check(ndes == (c.strobe_is_read_enable ? 0 : 1), "deselect count");
        check(clk_sel === c.interface_clock_sel, "clock select");
    endtask : access
    ////////////////////////////////////////////////////////////////
    initial begin
        logic [19:0] a;
        logic [63:0] d;
        void'($urandom(32'h3B41));
        cfg = '0;
        req = '0;
        cur_rl = 2'h0;
        cur_wl = 2'h0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        check(ready === 1'b1 && cs_n === 1'b1 && clk_sel === 1'b0, "reset state");
        repeat (10) @(negedge clk);
        for (int p = 0; p < 8; p += 4) begin
            for (int i = 0; i < 4; i++) program_space(p + i);  // All spaces first, held apart
            for (int i = 0; i < 4; i++) begin
                a = 20'($urandom());
                d = {$urandom(), $urandom()};
                access(1'b1, p + i, a, 8'hFF, d);
                access(1'b1, p + i, a, 8'($urandom()), ~d);
                access(1'b0, p + i, a, 8'h00, 64'h0);
            end
        end
        final_report();
    end
endmodule : tb_top
`default_nettype wire
